// ===== src/cold_load_detector.sv
// Cold load detector core with classic Wishbone register slave
`timescale 1ns/100ps
module cold_load_detector
   import cold_load_pkg::*;
(
   input wire logic clk_i, // System clock, 200 MHz
   input wire logic rst_i, // Synchronous reset, high
   input wire logic tick_i, // Program-cycle tick pulse
   input wire logic block_i, // Block from blocking matrix
   input wire logic [cold_load_pkg::MAG_W-1:0] mag_l1_i, // Phase 1 RMS
   input wire logic [cold_load_pkg::MAG_W-1:0] mag_l2_i, // Phase 2 RMS
   input wire logic [cold_load_pkg::MAG_W-1:0] mag_l3_i, // Phase 3 RMS
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Write enable
   input wire logic [cold_load_pkg::ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [3:0] wb_sel_i, // Byte enables
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   output logic cold_load_active_o, // Cold load active
   output logic blocked_o, // Pick-up blocked
   output logic [2:0] condition_o, // Condition code
   output logic [cold_load_pkg::EV_W-1:0] ev_on_o, // Rising event strobes
   output logic [cold_load_pkg::EV_W-1:0] ev_off_o // Falling event strobes
);

   import cold_load_pkg::*;

   typedef enum logic [2:0] {
      st_normal,
      st_delay,
      st_active,
      st_inrush,
      st_finish,
      st_blocked
   } det_state_e;

   det_state_e state_reg;
   logic [MAG_W-1:0] mag_smp [3];
   logic block_smp;
   logic upd1_reg;
   logic upd2_reg;
   logic upd3_reg;
   logic eval_seen_reg;
   logic [2:0] low_ex;
   logic [2:0] high_ex;
   logic [2:0] over_ex;
   logic low_cond;
   logic high_cond;
   logic over_cond;
   logic [TMR_W-1:0] start_cnt;
   logic [TMR_W-1:0] min_cnt;
   logic [TMR_W-1:0] max_cnt;
   logic [TMR_W-1:0] start_next;
   logic [TMR_W-1:0] min_next;
   logic [TMR_W-1:0] max_next;
   logic min_done;
   logic act_inc_reg;
   logic blk_inc_reg;
   logic [MAG_W-1:0] thr_low_reg;
   logic [MAG_W-1:0] thr_high_reg;
   logic [MAG_W-1:0] thr_over_reg;
   logic [TMR_W-1:0] t_set_reg;
   logic [TMR_W-1:0] t_max_reg;
   logic [TMR_W-1:0] t_min_reg;
   logic [CNT_W-1:0] cnt_act_reg;
   logic [CNT_W-1:0] cnt_blk_reg;
   logic clr_act;
   logic clr_blk;
   logic bus_req;
   logic bus_wr;
   logic is_active;
   logic [2:0] cond_next;
   logic [EV_W-1:0] ev_flags;
   logic [EV_W-1:0] ev_prev_reg;
   logic [31:0] status_word;
   logic [31:0] rd_next;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Saturating step keeps long holds from wrapping
   function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
      if (&v) begin
         return v;
      end
      return v + TMR_W'(1);
   endfunction

   // Byte-lane merge for a write
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Program-cycle sampling
   // ------------------------------------------------------------
   // Inputs frozen at the tick so one cycle sees one block value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mag_smp[0] <= '0;
         mag_smp[1] <= '0;
         mag_smp[2] <= '0;
         block_smp <= 1'b0;
      end else if (tick_i) begin
         mag_smp[0] <= mag_l1_i;
         mag_smp[1] <= mag_l2_i;
         mag_smp[2] <= mag_l3_i;
         block_smp <= block_i;
      end
   end

   // Pipeline of evaluation strobes after a tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd1_reg <= 1'b0;
         upd2_reg <= 1'b0;
         upd3_reg <= 1'b0;
         eval_seen_reg <= 1'b0;
      end else begin
         upd1_reg <= tick_i;
         upd2_reg <= upd1_reg;
         upd3_reg <= upd2_reg;
         eval_seen_reg <= eval_seen_reg | upd1_reg; // Comparators hold a real sample
      end
   end

   // ------------------------------------------------------------
   // Threshold comparators
   // ------------------------------------------------------------
   // Every phase sees the same three live thresholds
   for (genvar p = 0; p < 3; p++) begin : g_phase
      thr_hyst #(.MW(MAG_W)) u_low (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .upd_i(upd1_reg),
         .mag_i(mag_smp[p]),
         .thr_i(thr_low_reg),
         .exceed_o(low_ex[p])
      );
      thr_hyst #(.MW(MAG_W)) u_high (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .upd_i(upd1_reg),
         .mag_i(mag_smp[p]),
         .thr_i(thr_high_reg),
         .exceed_o(high_ex[p])
      );
      thr_hyst #(.MW(MAG_W)) u_over (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .upd_i(upd1_reg),
         .mag_i(mag_smp[p]),
         .thr_i(thr_over_reg),
         .exceed_o(over_ex[p])
      );
   end

   // Phase combination of the comparator states
   // Reset comparator state reads as low, so gate it until the first sample
   assign low_cond = eval_seen_reg && ~|low_ex;
   assign high_cond = &high_ex;
   assign over_cond = |over_ex;

   // ------------------------------------------------------------
   // Timers and state machine
   // ------------------------------------------------------------
   assign start_next = sat_inc(start_cnt);
   assign min_next = sat_inc(min_cnt);
   assign max_next = sat_inc(max_cnt);
   // Settings compared live, so a group change acts at once
   assign min_done = (min_next >= t_min_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= st_normal;
         start_cnt <= '0;
         min_cnt <= '0;
         max_cnt <= '0;
         act_inc_reg <= 1'b0;
         blk_inc_reg <= 1'b0;
      end else begin
         act_inc_reg <= 1'b0;
         blk_inc_reg <= 1'b0;
         if (upd2_reg) begin
            unique case (state_reg)
               st_normal: begin
                  start_cnt <= '0;
                  if (low_cond) begin
                     if (t_set_reg == '0) begin
                        if (block_smp) begin
                           state_reg <= st_blocked;
                           blk_inc_reg <= 1'b1;
                        end else begin
                           state_reg <= st_active;
                           min_cnt <= '0;
                           act_inc_reg <= 1'b1;
                        end
                     end else begin
                        state_reg <= st_delay;
                     end
                  end
               end
               st_delay: begin
                  if (!low_cond) begin
                     state_reg <= st_normal;
                     start_cnt <= '0;
                  end else if (start_next >= t_set_reg) begin
                     start_cnt <= '0;
                     if (block_smp) begin
                        state_reg <= st_blocked;
                        blk_inc_reg <= 1'b1;
                     end else begin
                        state_reg <= st_active;
                        min_cnt <= '0;
                        act_inc_reg <= 1'b1;
                     end
                  end else begin
                     start_cnt <= start_next;
                  end
               end
               st_active, st_inrush, st_finish: begin
                  min_cnt <= min_next;
                  if (over_cond || block_smp) begin
                     state_reg <= st_normal;
                  end else if (state_reg == st_active) begin
                     if (high_cond) begin
                        state_reg <= st_inrush;
                        max_cnt <= '0;
                     end else if (min_done && !low_cond) begin
                        state_reg <= st_normal;
                     end
                  end else if (state_reg == st_inrush) begin
                     if (!high_cond) begin
                        state_reg <= min_done ? st_normal : st_finish;
                     end else if (max_next >= t_max_reg) begin
                        state_reg <= st_normal;
                     end else begin
                        max_cnt <= max_next;
                     end
                  end else begin
                     // Second inrush keeps the maximum timer running
                     if (high_cond) begin
                        state_reg <= st_inrush;
                     end else if (min_done) begin
                        state_reg <= st_normal;
                     end
                  end
               end
               st_blocked: begin
                  if (!low_cond || !block_smp) begin
                     state_reg <= st_normal;
                  end
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs and condition code
   // ------------------------------------------------------------
   assign is_active = (state_reg == st_active) || (state_reg == st_inrush) || (state_reg == st_finish);

   // Priority order of the displayed condition
   always_comb begin
      if (is_active) begin
         cond_next = COND_ACTIVE;
      end else if (state_reg == st_blocked) begin
         cond_next = COND_BLOCKED;
      end else if (over_cond) begin
         cond_next = COND_OVER;
      end else if (low_cond) begin
         cond_next = COND_LOW;
      end else begin
         cond_next = COND_NORMAL;
      end
   end

   // Registered so outputs stay glitch free for the output matrix
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cold_load_active_o <= 1'b0;
         blocked_o <= 1'b0;
         condition_o <= COND_NORMAL;
      end else begin
         cold_load_active_o <= is_active;
         blocked_o <= (state_reg == st_blocked);
         condition_o <= cond_next;
      end
   end

   // ------------------------------------------------------------
   // Event strobes
   // ------------------------------------------------------------
   assign ev_flags[EV_LOW] = low_cond;
   assign ev_flags[EV_HIGH] = high_cond;
   assign ev_flags[EV_NORMAL] = (cond_next == COND_NORMAL);
   assign ev_flags[EV_OVER] = over_cond;
   assign ev_flags[EV_ACTIVE] = is_active;
   assign ev_flags[EV_BLOCK] = block_smp;

   // Edges seen once per program cycle, one clock wide
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_prev_reg <= EV_W'(1) << EV_NORMAL; // Load counts as normal out of reset
         ev_on_o <= '0;
         ev_off_o <= '0;
      end else if (upd3_reg) begin
         ev_prev_reg <= ev_flags;
         ev_on_o <= ev_flags & ~ev_prev_reg;
         ev_off_o <= ~ev_flags & ev_prev_reg;
      end else begin
         ev_on_o <= '0;
         ev_off_o <= '0;
      end
   end

   // ------------------------------------------------------------
   // Occurrence counters
   // ------------------------------------------------------------
   // A count arriving with a clear survives as the first count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_act_reg <= '0;
      end else if (act_inc_reg) begin
         cnt_act_reg <= clr_act ? CNT_W'(1) : cnt_act_reg + CNT_W'(1);
      end else if (clr_act) begin
         cnt_act_reg <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_blk_reg <= '0;
      end else if (blk_inc_reg) begin
         cnt_blk_reg <= clr_blk ? CNT_W'(1) : cnt_blk_reg + CNT_W'(1);
      end else if (clr_blk) begin
         cnt_blk_reg <= '0;
      end
   end

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;
   assign clr_act = bus_wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_CLR_ACT];
   assign clr_blk = bus_wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_CLR_BLK];

   // Settings writes, accepted at any time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thr_low_reg <= THR_LOW_DEF;
         thr_high_reg <= THR_HIGH_DEF;
         thr_over_reg <= THR_OVER_DEF;
         t_set_reg <= T_SET_DEF;
         t_max_reg <= T_MAX_DEF;
         t_min_reg <= T_MIN_DEF;
      end else if (bus_wr) begin
         unique case (wb_adr_i)
            ADR_LOW_THR: thr_low_reg <= MAG_W'(lane_merge(32'(thr_low_reg), wb_dat_i, wb_sel_i));
            ADR_HIGH_THR: thr_high_reg <= MAG_W'(lane_merge(32'(thr_high_reg), wb_dat_i, wb_sel_i));
            ADR_OVER_THR: thr_over_reg <= MAG_W'(lane_merge(32'(thr_over_reg), wb_dat_i, wb_sel_i));
            ADR_T_SET: t_set_reg <= TMR_W'(lane_merge(32'(t_set_reg), wb_dat_i, wb_sel_i));
            ADR_T_MAX: t_max_reg <= TMR_W'(lane_merge(32'(t_max_reg), wb_dat_i, wb_sel_i));
            ADR_T_MIN: t_min_reg <= TMR_W'(lane_merge(32'(t_min_reg), wb_dat_i, wb_sel_i));
            default: begin
            end
         endcase
      end
   end

   // Status word shows the live detector state
   always_comb begin
      status_word = '0;
      status_word[2:0] = cond_next;
      status_word[STS_ACTIVE] = is_active;
      status_word[STS_BLOCKED] = (state_reg == st_blocked);
      status_word[STS_LOW] = low_cond;
      status_word[STS_HIGH] = high_cond;
      status_word[STS_OVER] = over_cond;
      status_word[STS_BLOCK_IN] = block_smp;
   end

   // Read decode; unmapped offsets read zero
   always_comb begin
      unique case (wb_adr_i)
         ADR_STATUS: rd_next = status_word;
         ADR_LOW_THR: rd_next = 32'(thr_low_reg);
         ADR_HIGH_THR: rd_next = 32'(thr_high_reg);
         ADR_OVER_THR: rd_next = 32'(thr_over_reg);
         ADR_T_SET: rd_next = 32'(t_set_reg);
         ADR_T_MAX: rd_next = 32'(t_max_reg);
         ADR_T_MIN: rd_next = 32'(t_min_reg);
         ADR_CNT_ACT: rd_next = 32'(cnt_act_reg);
         ADR_CNT_BLK: rd_next = 32'(cnt_blk_reg);
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // One wait state answer; ack drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_next;
         end
      end
   end

endmodule

// ===== src/cold_load_pkg.sv
// Constants, register map and settings defaults of the cold load detector
//
// Function
// - Works on fundamental RMS phase magnitudes
// - Comparators release below 97 percent
// - One threshold shared by three phases
// - Low condition needs all phases below
// - High condition needs all phases above
// - Any phase overcurrent releases active immediately
// - Block sampled once per program cycle
// - Unblocked pick-up asserts active, runs timers
// - Blocked pick-up asserts blocked, no timers
// - Late block releases like pick-up end
// - Activate after low held start delay
// - High held to maximum timer releases
// - Minimum timer holds and reclaims active
// - Fall into band ends start-up
// - Zero start delay activates immediately
// - Low ending early discards start timer
// - Band without inrush releases at minimum
// - Inrush during minimum starts maximum timer
// - Readable five-valued condition code
// - Settings take effect while running
// - On and off event strobes
// - Resettable activation and block counters
package cold_load_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int MAG_W = 16;
   localparam int TMR_W = 19;
   localparam int ADR_W = 8;
   localparam int CNT_W = 16;
   localparam int EV_W = 6;

   // ------------------------------------------------------------
   // Hysteresis ratio, release below NUM/DEN of threshold
   // ------------------------------------------------------------
   localparam logic [6:0] HYST_NUM = 7'h61;
   localparam logic [6:0] HYST_DEN = 7'h64;

   // ------------------------------------------------------------
   // Timing, one program-cycle tick is one timer step
   // ------------------------------------------------------------
   localparam int TICK_MS = 5;
   localparam int T_SET_DEF_MS = 10000;
   localparam int T_MAX_DEF_MS = 30000;
   localparam int T_MIN_DEF_MS = 40;
   localparam logic [TMR_W-1:0] T_SET_DEF = TMR_W'(T_SET_DEF_MS / TICK_MS);
   localparam logic [TMR_W-1:0] T_MAX_DEF = TMR_W'(T_MAX_DEF_MS / TICK_MS);
   localparam logic [TMR_W-1:0] T_MIN_DEF = TMR_W'(T_MIN_DEF_MS / TICK_MS);

   // ------------------------------------------------------------
   // Threshold defaults in hundredths of nominal current
   // ------------------------------------------------------------
   localparam logic [MAG_W-1:0] THR_LOW_DEF = 16'h0014;
   localparam logic [MAG_W-1:0] THR_HIGH_DEF = 16'h0078;
   localparam logic [MAG_W-1:0] THR_OVER_DEF = 16'h00C8;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] ADR_LOW_THR = 8'h08;
   localparam logic [ADR_W-1:0] ADR_HIGH_THR = 8'h0C;
   localparam logic [ADR_W-1:0] ADR_OVER_THR = 8'h10;
   localparam logic [ADR_W-1:0] ADR_T_SET = 8'h14;
   localparam logic [ADR_W-1:0] ADR_T_MAX = 8'h18;
   localparam logic [ADR_W-1:0] ADR_T_MIN = 8'h1C;
   localparam logic [ADR_W-1:0] ADR_CNT_ACT = 8'h20;
   localparam logic [ADR_W-1:0] ADR_CNT_BLK = 8'h24;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_CLR_ACT = 0;
   localparam int CTRL_CLR_BLK = 1;
   localparam int STS_ACTIVE = 3;
   localparam int STS_BLOCKED = 4;
   localparam int STS_LOW = 5;
   localparam int STS_HIGH = 6;
   localparam int STS_OVER = 7;
   localparam int STS_BLOCK_IN = 8;

   // Event strobe bit positions
   localparam int EV_LOW = 0;
   localparam int EV_HIGH = 1;
   localparam int EV_NORMAL = 2;
   localparam int EV_OVER = 3;
   localparam int EV_ACTIVE = 4;
   localparam int EV_BLOCK = 5;

   // ------------------------------------------------------------
   // Condition codes
   // ------------------------------------------------------------
   localparam logic [2:0] COND_NORMAL = 3'h0;
   localparam logic [2:0] COND_LOW = 3'h1;
   localparam logic [2:0] COND_OVER = 3'h2;
   localparam logic [2:0] COND_ACTIVE = 3'h3;
   localparam logic [2:0] COND_BLOCKED = 3'h4;

endpackage

// ===== src/thr_hyst.sv
// Threshold comparator with built-in release hysteresis
`timescale 1ns/100ps
module thr_hyst
   import cold_load_pkg::*;
#(
   parameter int MW = MAG_W
) (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic upd_i, // Evaluate this cycle
   input wire logic [MW-1:0] mag_i, // Sampled magnitude
   input wire logic [MW-1:0] thr_i, // Live threshold
   output logic exceed_o // Threshold exceeded
);

   localparam int SW = MW + 7;

   logic [SW-1:0] mag_scaled;
   logic [SW-1:0] thr_scaled;
   logic exceed_reg;

   // ------------------------------------------------------------
   // Scaling
   // ------------------------------------------------------------
   // Cross-multiplied so no divider is needed for the ratio
   assign mag_scaled = SW'(mag_i) * SW'(HYST_DEN);
   assign thr_scaled = SW'(thr_i) * SW'(HYST_NUM);

   // Set above threshold, clear only below the reduced level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exceed_reg <= 1'b0;
      end else if (upd_i) begin
         if (mag_i > thr_i) begin
            exceed_reg <= 1'b1;
         end else if (mag_scaled < thr_scaled) begin
            exceed_reg <= 1'b0;
         end
      end
   end

   assign exceed_o = exceed_reg;

endmodule

// ===== tb/cold_load_assertions.sv
// Port-level checker for the cold load detector
`timescale 1ns/100ps
module cold_load_assertions
   import cold_load_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic tick_i, // Tick
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_ack_o, // Ack
   input wire logic cold_load_active_o, // Active
   input wire logic blocked_o, // Blocked
   input wire logic [2:0] condition_o, // Code
   input wire logic [cold_load_pkg::EV_W-1:0] ev_on_o, // On strobes
   input wire logic [cold_load_pkg::EV_W-1:0] ev_off_o // Off strobes
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers one cycle after a taken request, for one cycle
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   // Active and blocked never coexist, code follows them
   a_act_blk_excl: assert property (!(cold_load_active_o && blocked_o))
      else $error("active and blocked");
   a_cond_active: assert property (cold_load_active_o |-> condition_o == COND_ACTIVE)
      else $error("code not active");
   a_cond_blocked: assert property (blocked_o |-> condition_o == COND_BLOCKED)
      else $error("code not blocked");
   // Active is seen moving at the fourth edge after the sampled tick
   a_out_tick: assert property ($changed(cold_load_active_o) |-> $past(tick_i, 4))
      else $error("active moved off tick");
   a_ev_pulse: assert property (ev_on_o != 0 |=> ev_on_o == 0 && (ev_on_o & ev_off_o) == 0)
      else $error("event strobe width");
endmodule
bind cold_load_detector cold_load_assertions u_chk (.*);

// ===== tb/meas_model.sv
// Measurement and blocking matrix model: tick, phase magnitudes, block
`timescale 1ns/100ps
module meas_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [15:0] s1_i, s2_i, s3_i, // Requested RMS levels
   input wire logic blk_i, // Requested block
   output logic tick_o, // Program-cycle tick
   output logic [15:0] m1_o, m2_o, m3_o, // Fundamental RMS values
   output logic block_o // Block to detector
);
   logic [2:0] cnt_reg = 3'h0;
   // Tick every 8 cycles, well above the 3-cycle minimum
   always_ff @(posedge clk_i) begin
      cnt_reg <= rst_i ? 3'h0 : cnt_reg + 3'h1;
      tick_o <= !rst_i && cnt_reg == 3'h7;
   end
   // Levels settle a whole cycle ahead of the tick
   always_ff @(posedge clk_i) begin
      {m1_o, m2_o, m3_o} <= {s1_i, s2_i, s3_i};
      block_o <= blk_i;
   end
endmodule

// ===== tb/testbench.sv
// Scenario testbench for the cold load detector
`timescale 1ns/100ps
module testbench;
   import cold_load_pkg::*;
   localparam logic [15:0] LO = 16'h000A, BD = 16'h0032, HI = 16'h0096, OV = 16'h00FA;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, blk = 0;
   logic tick, block, ack, act, bl;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [15:0] s1 = BD, s2 = BD, s3 = BD, m1, m2, m3;
   logic [2:0] cond;
   logic [5:0] eon, eoff;
   int mismatches = 0, total_checks = 0;
   initial forever #2.5 clk_i = ~clk_i;
   meas_model i_meas (.clk_i(clk_i), .rst_i(rst_i), .s1_i(s1), .s2_i(s2), .s3_i(s3), .blk_i(blk),
      .tick_o(tick), .m1_o(m1), .m2_o(m2), .m3_o(m3), .block_o(block));
   cold_load_detector i_dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .block_i(block),
      .mag_l1_i(m1), .mag_l2_i(m2), .mag_l3_i(m3), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cold_load_active_o(act), .blocked_o(bl), .condition_o(cond), .ev_on_o(eon), .ev_off_o(eoff));
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask
   // Wait n ticks, then four more cycles for the pipeline
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i iff tick);
      repeat (4) @(posedge clk_i);
   endtask
   task automatic setm(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input int n);
      {s1, s2, s3} <= {a, b, c};
      @(posedge clk_i);
      tk(n);
   endtask
   task automatic act_on;
      setm(LO, LO, LO, 3);
      chk("act_on", 1, act);
      chk("ev_act", 1 << EV_ACTIVE, eon);
   endtask
   task automatic t_regs;
      rchk("low", ADR_LOW_THR, 32'(THR_LOW_DEF));
      rchk("tset", ADR_T_SET, 32'(T_SET_DEF));
      rchk("tmin", ADR_T_MIN, 32'(T_MIN_DEF));
      rchk("sts", ADR_STATUS, 32'h0);
      rchk("unmapped", 8'h40, 32'h0);
      wb(1'b1, ADR_T_SET, 32'h2);
      wb(1'b1, ADR_T_MIN, 32'h3);
      wb(1'b1, ADR_T_MAX, 32'h4);
      rchk("tset2", ADR_T_SET, 32'h2);
   endtask
   task automatic t_start;
      setm(LO, LO, LO, 2);
      chk("early", 0, act);
      chk("cond_low", COND_LOW, cond);
      setm(LO, BD, LO, 1);
      setm(LO, LO, LO, 2);
      chk("discard", 0, act);
      tk(1);
      chk("act", 1, act);
      chk("cond_act", COND_ACTIVE, cond);
      setm(BD, BD, BD, 1);
      chk("hold", 1, act);
      tk(3);
      chk("min_rel", 0, act);
   endtask
   task automatic t_inrush;
      wb(1'b1, ADR_T_MIN, 32'h6);
      act_on();
      setm(HI, HI, HI, 1);
      setm(BD, BD, BD, 1);
      chk("band_hold", 1, act);
      tk(7);
      chk("band_rel", 0, act);
      act_on();
      setm(HI, HI, 16'h0076, 1);
      chk("not_all", 1, act);
      setm(HI, HI, HI, 1);
      setm(16'h0076, HI, HI, 1);
      rchk("hyst_hold", ADR_STATUS, {24'h0, 1'b0, 1'b1, 2'b00, 1'b1, COND_ACTIVE});
      setm(HI, HI, HI, 6);
      chk("max_rel", 0, act);
      setm(16'h0074, HI, HI, 1);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("hyst_clr", 0, q[STS_HIGH]);
   endtask
   task automatic t_over;
      act_on();
      setm(OV, LO, LO, 1);
      chk("over_rel", 0, act);
      chk("cond_over", COND_OVER, cond);
      setm(BD, BD, BD, 1);
      blk <= 1'b1;
      setm(LO, LO, LO, 3);
      chk("blocked", 1, bl);
      chk("cond_blk", COND_BLOCKED, cond);
      setm(BD, BD, BD, 1);
      blk <= 1'b0;
      act_on();
      blk <= 1'b1;
      tk(1);
      chk("late_blk", 0, act);
      chk("ev_off", 1 << EV_ACTIVE, eoff);
      chk("ev_blk", 1 << EV_BLOCK, eon);
      blk <= 1'b0;
      setm(BD, BD, BD, 1);
      rchk("cnt_act", ADR_CNT_ACT, 32'h5);
      rchk("cnt_blk", ADR_CNT_BLK, 32'h1);
      wb(1'b1, ADR_CTRL, 32'h3);
      rchk("cnt_clr", ADR_CNT_ACT, 32'h0);
      wb(1'b1, ADR_T_SET, 32'h0);
      setm(LO, LO, LO, 1);
      chk("zero_dly", 1, act);
   endtask
   task automatic summarize;
      if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog, run needs well under 2000 cycles
   initial begin
      #100us;
      mismatches++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_start();
      t_inrush();
      t_over();
      summarize();
   end
endmodule
